// File: logic/twsp_pkg.sv
// constants, states and register map of the two-wire serial port
//==============================================================
// Overview of operation
// [RULE_01] with drive enable set, data pin follows the software data-out bit 7
// [RULE_02] bit 6 makes the data pin an output when set, input when clear
// [RULE_03] software master mode always drives the clock pin from bit 5
// [RULE_04] with drive enable clear, data pin is latched into bit 4 on clock rise
// [RULE_05] bit 3 selects software master when set; reset gives hardware slave
// [RULE_06] slave reset bit 2 holds the slave engine idle while set
// [RULE_07] received read/write bit lands in bit 1 and sets slave direction
// [RULE_08] byte done flag bit 0 sets after each acknowledged byte, not after nack
// [RULE_09] any data register access clears byte done flag and pending request
// [RULE_10] second data access within one byte event halts slave until slave reset
// [RULE_11] slave waits for start, then address match and direction set the flag
// [RULE_12] slave matches against a 7-bit writable address, reset value 55h; the code also acknowledges address byte 00h
// [RULE_13] first event leaves address and read/write bit in the data register
// [RULE_14] after a valid address the slave stretches clock until flag cleared
// [RULE_15] events continue until stop or reset; stop or nack returns to idle
// [RULE_16] byte done request marks the end of every acknowledged byte
// [RULE_17] core request needs both port enable and global enable
// [RULE_18] spikes shorter than 50 ns on data and clock are rejected
// [RULE_19] the port owns the pins only while the spi select bit is clear
// [RULE_20] software tells address events from data events by itself
// [RULE_21] software sequences data-out, clock-out and drive bits as a master
// [RULE_22] control register at address e8h, bit addressable, resets to 00h
// [RULE_23] slave acknowledges a matching address and each received byte
package twsp_pkg;
	//==============================================================
	// register map
	localparam logic [7:0] ADDR_BUS_DATA    = 8'h9a;
	localparam logic [7:0] ADDR_OWN_ADDRESS = 8'h9b;
	localparam logic [7:0] ADDR_CONTROL     = 8'he8;
	localparam logic [7:0] RST_BUS_DATA     = 8'h00;
	localparam logic [7:0] RST_OWN_ADDRESS  = 8'h55;
	localparam logic [7:0] RST_CONTROL      = 8'h00;
	//==============================================================
	// control bit positions
	localparam int BIT_MDATA_OUT = 7;
	localparam int BIT_MDRIVE_EN = 6;
	localparam int BIT_MCLK_OUT  = 5;
	localparam int BIT_MDATA_IN  = 4;
	localparam int BIT_MASTER    = 3;
	localparam int BIT_SRESET    = 2;
	localparam int BIT_DIR       = 1;
	localparam int BIT_DONE      = 0;
	//==============================================================
	// timing and fifo size
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SPIKE_PS      = 50000;
	localparam int SPIKE_CYC     = (SPIKE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FIFO_WIDTH    = 8;
	localparam int FIFO_DEPTH    = 16;
	//==============================================================
	// slave states, gray along the usual path
	typedef enum logic [2:0] {
		TWSP_IDLE  = 3'b000,
		TWSP_SHIFT = 3'b001,
		TWSP_ACK   = 3'b011,
		TWSP_WAIT  = 3'b010,
		TWSP_SEND  = 3'b110,
		TWSP_RACK  = 3'b111,
		TWSP_HALT  = 3'b101
	} twsp_state_t;
endpackage

// File: logic/twsp_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module twsp_fifo
	import twsp_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             flush
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic [AW:0]      level;

	// occupancy and handshakes
	assign level     = wr_ptr - rd_ptr;
	assign in_ready  = (level != (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// write side
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
		end else if (in_valid && in_ready) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	// read side
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr <= '0;
		end else if (flush) begin
			rd_ptr <= '0;
		end else if (out_valid && out_ready) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // twsp_fifo

// File: logic/twsp_port.sv
// two-wire port: hardware slave and software master
`timescale 1ns/100ps
module twsp_port
	import twsp_pkg::*;
(
	input  wire logic       CORE_CLK,
	input  wire logic       RST_N,
	input  wire logic [7:0] SFR_ADDR,
	input  wire logic       SFR_WR,
	input  wire logic       SFR_RD,
	input  wire logic [7:0] SFR_WDATA,
	output logic      [7:0] SFR_RDATA,
	input  wire logic       SPI_PIN_SELECT,
	input  wire logic       PORT_IRQ_ENABLE,
	input  wire logic       GLOBAL_IRQ_ENABLE,
	output logic            BYTE_IRQ,
	input  wire logic       SERIAL_DATA_IN,
	output logic            SERIAL_DATA_OUT,
	output logic            SERIAL_DATA_OE,
	input  wire logic       SERIAL_CLOCK_IN,
	output logic            SERIAL_CLOCK_OUT,
	output logic            SERIAL_CLOCK_OE
);
	//==============================================================
	// registers
	logic [7:0]  bus_data;
	logic [7:0]  own_slave_address;
	logic        sw_master_data_out, sw_master_data_drive_en;
	logic        sw_master_clock_out, sw_master_data_in;
	logic        master_select, slave_iface_reset;
	logic        slave_direction_flag, byte_done_flag;
	logic        accessed;     // data touched in this event
	twsp_state_t state;
	logic [2:0]  bit_cnt;
	logic [7:0]  shreg;
	logic        is_addr;
	logic        got_byte;     // eight bits shifted in since last slot
	logic        sda_drive_low, scl_hold;

	//==============================================================
	// pin synchronisers and spike filters
	logic [1:0] sda_sync, scl_sync;
	logic       sda_f, scl_f, sda_q, scl_q;
	logic [2:0] sda_cnt, scl_cnt;

	// two flops per pin
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_sync <= 2'h3;
			scl_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], SERIAL_DATA_IN};
			scl_sync <= {scl_sync[0], SERIAL_CLOCK_IN};
		end
	end

	// [RULE_18] spike rejection filter
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_f   <= 1'b1;
			scl_f   <= 1'b1;
			sda_cnt <= '0;
			scl_cnt <= '0;
		end else begin
			if (sda_sync[1] == sda_f) sda_cnt <= '0;
			else if (sda_cnt == 3'(SPIKE_CYC - 1)) begin
				sda_f   <= sda_sync[1];
				sda_cnt <= '0;
			end else sda_cnt <= sda_cnt + 1'b1;
			if (scl_sync[1] == scl_f) scl_cnt <= '0;
			else if (scl_cnt == 3'(SPIKE_CYC - 1)) begin
				scl_f   <= scl_sync[1];
				scl_cnt <= '0;
			end else scl_cnt <= scl_cnt + 1'b1;
		end
	end

	// delayed copies for edge detection
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_q <= 1'b1;
			scl_q <= 1'b1;
		end else begin
			sda_q <= sda_f;
			scl_q <= scl_f;
		end
	end

	logic scl_rise, scl_fall, start_det, stop_det;
	assign scl_rise  = scl_f & ~scl_q;
	assign scl_fall  = ~scl_f & scl_q;
	assign start_det = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;

	//==============================================================
	// register bus decode
	logic wr_data, wr_addr, wr_ctl, data_acc, slave_on;
	always_comb begin
		wr_data = 1'b0;
		wr_addr = 1'b0;
		wr_ctl  = 1'b0;
		if (SFR_ADDR == ADDR_BUS_DATA) wr_data = SFR_WR;
		else if (SFR_ADDR == ADDR_OWN_ADDRESS) wr_addr = SFR_WR;
		else if (SFR_ADDR == ADDR_CONTROL) wr_ctl = SFR_WR;
	end
	assign data_acc = (SFR_ADDR == ADDR_BUS_DATA) & (SFR_WR | SFR_RD);
	// [RULE_19] pins owned only when spi deselected
	assign slave_on = ~SPI_PIN_SELECT & ~master_select & ~slave_iface_reset;

	// read mux, unmapped reads zero
	always_comb begin
		if (SFR_ADDR == ADDR_BUS_DATA) SFR_RDATA = bus_data;
		else if (SFR_ADDR == ADDR_OWN_ADDRESS) SFR_RDATA = own_slave_address;
		else if (SFR_ADDR == ADDR_CONTROL)
			SFR_RDATA = {sw_master_data_out, sw_master_data_drive_en,
				sw_master_clock_out, sw_master_data_in, master_select,
				slave_iface_reset, slave_direction_flag, byte_done_flag};
		else SFR_RDATA = 8'h00;
	end

	// [RULE_22] control bits written by software
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			{sw_master_data_out, sw_master_data_drive_en,
			 sw_master_clock_out} <= RST_CONTROL[7:5];
			master_select     <= RST_CONTROL[BIT_MASTER];
			slave_iface_reset <= RST_CONTROL[BIT_SRESET];
		end else if (wr_ctl) begin
			// [RULE_05] mode select bit
			sw_master_data_out      <= SFR_WDATA[BIT_MDATA_OUT];
			sw_master_data_drive_en <= SFR_WDATA[BIT_MDRIVE_EN];
			sw_master_clock_out     <= SFR_WDATA[BIT_MCLK_OUT];
			master_select           <= SFR_WDATA[BIT_MASTER];
			slave_iface_reset       <= SFR_WDATA[BIT_SRESET];
		end
	end

	// [RULE_12] own address register
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) own_slave_address <= RST_OWN_ADDRESS;
		else if (wr_addr) own_slave_address <= SFR_WDATA;
	end

	// [RULE_04] data in latched on clock rise when not driving
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) sw_master_data_in <= RST_CONTROL[BIT_MDATA_IN];
		else if (scl_rise && !sw_master_data_drive_en)
			sw_master_data_in <= sda_f;
	end

	//==============================================================
	// transmit fifo: software writes, slave send drains
	logic       tx_valid, tx_take, tx_ready;
	logic [7:0] tx_byte;
	twsp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_txq (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.in_valid  (wr_data),
		.in_ready  (tx_ready),
		.in_data   (SFR_WDATA),
		.out_valid (tx_valid),
		.out_ready (tx_take),
		.out_data  (tx_byte),
		.flush     (state == TWSP_IDLE)
	);

	//==============================================================
	// slave engine
	logic set_done;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state   <= TWSP_IDLE;
			bit_cnt <= '0;
			shreg   <= '0;
			is_addr <= 1'b0;
			got_byte <= 1'b0;
			slave_direction_flag <= 1'b0;
			sda_drive_low <= 1'b0;
			tx_take <= 1'b0;
			set_done <= 1'b0;
		end else begin
			tx_take  <= 1'b0;
			set_done <= 1'b0;
			// [RULE_06] slave reset forces idle
			if (!slave_on) begin
				state <= TWSP_IDLE;
				sda_drive_low <= 1'b0;
			// [RULE_10] double access halts
			end else if (state != TWSP_IDLE && data_acc && accessed) begin
				state <= TWSP_HALT;
				sda_drive_low <= 1'b0;
			// [RULE_11] wait for start
			end else if (start_det && state != TWSP_HALT) begin
				state   <= TWSP_SHIFT;
				bit_cnt <= '0;
				is_addr <= 1'b1;
				got_byte <= 1'b0;
				sda_drive_low <= 1'b0;
			// [RULE_15] stop returns idle
			end else if (stop_det && state != TWSP_HALT) begin
				state <= TWSP_IDLE;
				sda_drive_low <= 1'b0;
			end else begin
				case (state)
				TWSP_SHIFT: begin
					if (scl_rise) begin
						shreg   <= {shreg[6:0], sda_f};
						bit_cnt <= bit_cnt + 1'b1;
						// eighth rise completes the byte
						if (bit_cnt == 3'h7) got_byte <= 1'b1;
					end else if (scl_fall && got_byte && shreg != 8'h00
						&& is_addr && shreg[7:1] != own_slave_address[6:0]) begin
						state <= TWSP_IDLE;
						got_byte <= 1'b0;
					end else if (scl_fall && got_byte) begin
						// [RULE_23] acknowledge address or byte
						state <= TWSP_ACK;
						sda_drive_low <= 1'b1;
						got_byte <= 1'b0;
						if (is_addr) slave_direction_flag <= shreg[0]; // [RULE_07]
					end
				end
				TWSP_ACK: if (scl_fall) begin
					sda_drive_low <= 1'b0;
					set_done <= 1'b1;           // [RULE_08]
					state    <= TWSP_WAIT;
				end
				TWSP_WAIT: begin
					// [RULE_14] clock held until flag cleared
					if (!byte_done_flag && !set_done) begin
						is_addr <= 1'b0;
						if (slave_direction_flag) begin
							state <= TWSP_SEND;
							shreg <= tx_valid ? tx_byte : 8'hff;
							tx_take <= tx_valid;
							sda_drive_low <= tx_valid ? ~tx_byte[7] : 1'b0;
							bit_cnt <= '0;
						end else begin
							state <= TWSP_SHIFT;
							bit_cnt <= '0;
						end
					end
				end
				TWSP_SEND: begin
					if (scl_fall) begin
						if (bit_cnt == 3'h7) begin
							sda_drive_low <= 1'b0;
							state <= TWSP_RACK;
						end else begin
							sda_drive_low <= ~shreg[6];
							shreg <= {shreg[6:0], 1'b1};
						end
						bit_cnt <= bit_cnt + 1'b1;
					end
				end
				TWSP_RACK: if (scl_rise) begin
					// [RULE_15] nack ends sequence, no flag
					if (sda_f) state <= TWSP_IDLE;
					else begin
						set_done <= 1'b1;
						state    <= TWSP_WAIT;
					end
				end
				default: ;
				endcase
			end
		end
	end
	assign scl_hold = (state == TWSP_WAIT) & (byte_done_flag | set_done);

	// [RULE_08] byte done flag, set wins over clear
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) byte_done_flag <= 1'b0;
		else if (set_done) byte_done_flag <= 1'b1;
		// [RULE_09] data access clears flag
		else if (data_acc || !slave_on) byte_done_flag <= 1'b0;
	end

	// one access allowed per event
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) accessed <= 1'b0;
		else if (set_done) accessed <= 1'b0;
		else if (!slave_on) accessed <= 1'b0;
		else if (data_acc) accessed <= 1'b1;
	end

	// [RULE_13] received byte or address into data register
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) bus_data <= RST_BUS_DATA;
		else if (wr_data) bus_data <= SFR_WDATA;
		else if (state == TWSP_ACK && scl_fall && !slave_direction_flag)
			bus_data <= shreg;
		else if (state == TWSP_ACK && scl_fall && is_addr)
			bus_data <= shreg;
	end

	// [RULE_16] [RULE_17] gated request
	assign BYTE_IRQ = byte_done_flag & PORT_IRQ_ENABLE & GLOBAL_IRQ_ENABLE;

	//==============================================================
	// pin drivers
	always_comb begin
		SERIAL_DATA_OUT  = 1'b0;
		SERIAL_DATA_OE   = 1'b0;
		SERIAL_CLOCK_OUT = 1'b0;
		SERIAL_CLOCK_OE  = 1'b0;
		if (!SPI_PIN_SELECT && master_select) begin
			// [RULE_01] [RULE_02] data pin
			SERIAL_DATA_OUT = sw_master_data_out;
			SERIAL_DATA_OE  = sw_master_data_drive_en;
			// [RULE_03] clock always driven
			SERIAL_CLOCK_OUT = sw_master_clock_out;
			SERIAL_CLOCK_OE  = 1'b1;
		end else if (slave_on) begin
			SERIAL_DATA_OE  = sda_drive_low;
			SERIAL_CLOCK_OE = scl_hold;
		end
	end
endmodule // twsp_port

// File: dv/twsp_checker.sv
// concurrent checks on the port's pins, flag and interrupt request
`timescale 1ns/100ps
module twsp_checker
	import twsp_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	input wire logic [7:0] SFR_ADDR,
	input wire logic       SFR_WR,
	input wire logic       SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	input wire logic       SPI_PIN_SELECT,
	input wire logic       PORT_IRQ_ENABLE,
	input wire logic       GLOBAL_IRQ_ENABLE,
	input wire logic       BYTE_IRQ,
	input wire logic       SERIAL_DATA_OUT,
	input wire logic       SERIAL_DATA_OE,
	input wire logic       SERIAL_CLOCK_OUT,
	input wire logic       SERIAL_CLOCK_OE
);
	logic [7:0] ctl;
	//==============================================================
	// mirror of the control bits software writes
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N)
			ctl <= 8'h00;
		else if (SFR_WR && SFR_ADDR == ADDR_CONTROL)
			ctl <= SFR_WDATA;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	//==============================================================
	// pin and request checks
	a_sda_follows_bit: assert property (
		ctl[BIT_MASTER] && ctl[BIT_MDRIVE_EN] && !SPI_PIN_SELECT |->
		SERIAL_DATA_OE && SERIAL_DATA_OUT == ctl[BIT_MDATA_OUT])
		else $error("data pin does not follow data-out bit");
	a_sda_input_mode: assert property (
		ctl[BIT_MASTER] && !ctl[BIT_MDRIVE_EN] |-> !SERIAL_DATA_OE)
		else $error("data pin driven while set as input");
	a_scl_master_out: assert property (
		ctl[BIT_MASTER] && !SPI_PIN_SELECT |->
		SERIAL_CLOCK_OE && SERIAL_CLOCK_OUT == ctl[BIT_MCLK_OUT])
		else $error("clock pin does not follow clock-out bit");
	a_irq_enable_gate: assert property (
		BYTE_IRQ |-> PORT_IRQ_ENABLE && GLOBAL_IRQ_ENABLE)
		else $error("request raised without both enables");
	a_pins_given_away: assert property (
		SPI_PIN_SELECT [*2] |-> !SERIAL_DATA_OE && !SERIAL_CLOCK_OE)
		else $error("pins driven while handed to the other block");
	a_access_clears_flag: assert property (
		(SFR_RD || SFR_WR) && SFR_ADDR == ADDR_BUS_DATA && BYTE_IRQ
		|=> !BYTE_IRQ)
		else $error("data access did not clear the request");
	a_stretch_on_flag: assert property (
		$rose(BYTE_IRQ) && !ctl[BIT_MASTER] |->
		##[0:2] (SERIAL_CLOCK_OE && !SERIAL_CLOCK_OUT))
		else $error("clock not held low after byte event");
	a_slave_drives_low: assert property (
		!ctl[BIT_MASTER] && SERIAL_DATA_OE |-> !SERIAL_DATA_OUT)
		else $error("slave drove the data line high");
endmodule // twsp_checker

bind twsp_port twsp_checker i_chk (.CORE_CLK, .RST_N, .SFR_ADDR, .SFR_WR,
	.SFR_RD, .SFR_WDATA, .SPI_PIN_SELECT, .PORT_IRQ_ENABLE,
	.GLOBAL_IRQ_ENABLE, .BYTE_IRQ, .SERIAL_DATA_OUT, .SERIAL_DATA_OE,
	.SERIAL_CLOCK_OUT, .SERIAL_CLOCK_OE);

// File: dv/twsp_far_master.sv
// far-side bus master pulling the shared lines low against pull-ups
`timescale 1ns/100ps
module twsp_far_master (
	input  wire logic clk,
	input  wire logic sda,
	input  wire logic scl,
	output logic      sda_low,
	output logic      scl_low
);
	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
	end
	// one bit: low phase, then high phase once the slave lets go
	task automatic bit_io(input logic b, output logic r);
		@(posedge clk) sda_low <= !b;
		repeat (6) @(posedge clk);
		scl_low <= 1'b0;
		for (int i = 0; i < 3000 && !scl; i++)
			@(posedge clk);
		repeat (8) @(posedge clk);
		r = sda;
		scl_low <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic start();
		@(posedge clk) sda_low <= 1'b0;
		repeat (4) @(posedge clk);
		scl_low <= 1'b0;
		repeat (9) @(posedge clk);
		sda_low <= 1'b1;
		repeat (9) @(posedge clk);
		scl_low <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic stop();
		@(posedge clk) sda_low <= 1'b1;
		repeat (6) @(posedge clk);
		scl_low <= 1'b0;
		repeat (9) @(posedge clk);
		sda_low <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	// eight bits msb first plus the acknowledge slot
	task automatic xfer(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--)
			bit_io(o[k], i[k]);
	endtask
endmodule // twsp_far_master

// File: dv/tb_top.sv
// bench for the two-wire port: registers, software master, slave traffic
`timescale 1ns/100ps
module tb_top;
	import twsp_pkg::*;
	logic       clk, rst_n, wr, rd, spi, pen, gen, irq;
	logic       dout, doe, cout, coe, m_sda, m_scl;
	logic [7:0] addr, wdata, rdata;
	logic [8:0] rx;
	wire        sda, scl;
	int         failures, tests_run;
	// open-drain lines with pull-ups
	assign sda = !((doe && !dout) || m_sda);
	assign scl = !((coe && !cout) || m_scl);
	twsp_port i_dut (.CORE_CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr),
		.SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
		.SPI_PIN_SELECT(spi), .PORT_IRQ_ENABLE(pen),
		.GLOBAL_IRQ_ENABLE(gen), .BYTE_IRQ(irq), .SERIAL_DATA_IN(sda),
		.SERIAL_DATA_OUT(dout), .SERIAL_DATA_OE(doe),
		.SERIAL_CLOCK_IN(scl), .SERIAL_CLOCK_OUT(cout),
		.SERIAL_CLOCK_OE(coe));
	twsp_far_master i_far (.clk(clk), .sda(sda), .scl(scl),
		.sda_low(m_sda), .scl_low(m_scl));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	//==============================================================
	// shared tasks
	task automatic chk(input string n, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a, e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		chk(n, e, rdata);
	endtask
	task automatic irq_chk(input logic e);
		for (int i = 0; i < 40 && irq !== 1'b1; i++)
			@(posedge clk);
		chk("byte irq", {7'h00, e}, {7'h00, irq});
	endtask
	task automatic send(input logic [8:0] o, input logic ack);
		i_far.xfer(o, rx);
		chk("ack slot", {7'h00, !ack}, {7'h00, rx[0]});
	endtask
	task automatic complete_run();
		$display("comparisons %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	//==============================================================
	// scenarios
	task automatic t_reset();
		rd_chk("data reg", ADDR_BUS_DATA, 8'h00);
		rd_chk("own addr", ADDR_OWN_ADDRESS, 8'h55);
		rd_chk("control", ADDR_CONTROL, 8'h00);
		rd_chk("unmapped", 8'h10, 8'h00);
		spi <= 1'b1;
		repeat (4) @(posedge clk);
		spi <= 1'b0;
	endtask
	task automatic t_master();
		wr_reg(ADDR_CONTROL, 8'he8);
		@(posedge clk);
		chk("data pin", 8'h03, {6'h00, doe, dout});
		chk("clock pin", 8'h03, {6'h00, coe, cout});
		i_far.sda_low <= 1'b1;
		wr_reg(ADDR_CONTROL, 8'h08);
		repeat (12) @(posedge clk);
		wr_reg(ADDR_CONTROL, 8'h28);
		repeat (12) @(posedge clk);
		rd_chk("data in low", ADDR_CONTROL, 8'h28);
		i_far.sda_low <= 1'b0;
		wr_reg(ADDR_CONTROL, 8'h08);
		repeat (12) @(posedge clk);
		wr_reg(ADDR_CONTROL, 8'h28);
		repeat (12) @(posedge clk);
		rd_chk("data in high", ADDR_CONTROL, 8'h38);
		wr_reg(ADDR_CONTROL, 8'h00);
	endtask
	task automatic t_slave_rx();
		wr_reg(ADDR_OWN_ADDRESS, 8'h2a);
		i_far.start();
		send(9'h0a9, 1'b1);
		irq_chk(1'b1);
		gen <= 1'b0;
		@(posedge clk);
		chk("gated irq", 8'h00, {7'h00, irq});
		gen <= 1'b1;
		rd_chk("direction", ADDR_CONTROL, 8'h01);
		rd_chk("addr byte", ADDR_BUS_DATA, 8'h54);
		send(9'h14b, 1'b1);
		irq_chk(1'b1);
		rd_chk("rx byte", ADDR_BUS_DATA, 8'ha5);
		i_far.stop();
	endtask
	task automatic t_slave_tx();
		i_far.start();
		send(9'h0ab, 1'b1);
		irq_chk(1'b1);
		rd_chk("direction", ADDR_CONTROL, 8'h03);
		wr_reg(ADDR_BUS_DATA, 8'h3c);
		i_far.xfer(9'h1ff, rx);
		chk("tx byte", 8'h3c, rx[8:1]);
		irq_chk(1'b0);
		i_far.stop();
	endtask
	task automatic t_wrong_addr();
		i_far.start();
		send(9'h0ad, 1'b0);
		irq_chk(1'b0);
		i_far.stop();
	endtask
	task automatic t_halt();
		i_far.start();
		send(9'h0a9, 1'b1);
		irq_chk(1'b1);
		rd_chk("addr byte", ADDR_BUS_DATA, 8'h54);
		rd_chk("second read", ADDR_BUS_DATA, 8'h54);
		send(9'h023, 1'b0);
		i_far.stop();
		wr_reg(ADDR_CONTROL, 8'h04);
		wr_reg(ADDR_CONTROL, 8'h00);
		i_far.start();
		send(9'h0a9, 1'b1);
		irq_chk(1'b1);
		rd_chk("addr byte", ADDR_BUS_DATA, 8'h54);
		i_far.stop();
	endtask
	//==============================================================
	// main sequence and watchdog
	initial begin
		{rst_n, wr, rd, spi} = 4'h0;
		{pen, gen} = 2'b11;
		addr = 8'h00;
		wdata = 8'h00;
		failures = 0;
		tests_run = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_master();
		t_slave_rx();
		t_slave_tx();
		t_wrong_addr();
		t_halt();
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		complete_run();
	end
endmodule // tb_top
